// file: core/ahb_reg_port.sv
// AHB-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/100ps
module ahb_reg_port (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	reg_access_if.port ra
);

	logic [31:0] hrdata_reg;
	logic hreadyout_reg;
	logic wr_pend_reg;
	logic rd_pend_reg;
	logic [7:0] addr_reg;
	logic [3:0] be_reg;
	wire addr_phase = hsel && hready && htrans[1];

	// Byte lanes from size and low address bits
	function automatic logic [3:0] lanes(input logic [2:0] size, input logic [1:0] a);
		logic [3:0] l;
		l = 4'hF;
		if (size == 3'h0) begin
			l = 4'(4'h1 << a);
		end else if (size == 3'h1) begin
			l = a[1] ? 4'hC : 4'h3;
		end
		return l;
	endfunction

	// Writes take effect in the data phase, when hwdata is valid
	assign ra.wr_en = wr_pend_reg;
	assign ra.wr_addr = addr_reg;
	assign ra.wr_be = be_reg;
	assign ra.wr_data = hwdata;
	assign ra.rd_en = rd_pend_reg;
	assign ra.rd_addr = addr_reg;
	assign hrdata = hrdata_reg;
	assign hreadyout = hreadyout_reg;
	assign hresp = 1'b0;

	// Reads insert one wait state so a write just before is seen
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			be_reg <= 4'h0;
			hreadyout_reg <= 1'b1;
			hrdata_reg <= 32'h00000000;
		end else begin
			wr_pend_reg <= addr_phase && hwrite;
			rd_pend_reg <= addr_phase && !hwrite;
			if (addr_phase) begin
				addr_reg <= {haddr[7:2], 2'h0};
				be_reg <= lanes(hsize, haddr[1:0]);
			end
			hreadyout_reg <= !(addr_phase && !hwrite);
			if (rd_pend_reg) begin
				hrdata_reg <= ra.rd_data;
			end
		end
	end

endmodule

// file: core/reg_access_if.sv
// Register access carrier between the bus port and the register file
`timescale 1ns/100ps
interface reg_access_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [3:0] wr_be;
	logic [31:0] wr_data;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;

	modport port (output wr_en, output wr_addr, output wr_be, output wr_data,
		output rd_en, output rd_addr, input rd_data);
	modport regs (input wr_en, input wr_addr, input wr_be, input wr_data,
		input rd_en, input rd_addr, output rd_data);
endinterface

// file: core/timer16_channel.sv
// One 16-bit timer/event counter channel with its AHB-Lite register file
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps

// Notes on behaviour
// - Run field picks stop, free, edge-clear, match-clear
// - Counting starts the cycle run becomes non-zero
// - Control registers reset to zero, byte writable
// - Invert select adds input-A edge toggling output
// - Overflow flag sets on FFFF to 0000 wrap
// - Flag clears on write 0 or stop
// - Writing 1 sets the overflow flag while running
// - Mode bit 0 compares, 1 captures
// - Trigger select picks input B or reverse A
// - Reverse-A trigger turns input B into interrupt
// - Both-edge input A with reverse trigger is dead
// - Valid edges come from prescaler edge selects
// - Running: only one-shot trigger and B-invert bits of output control writable
// - Count increments on each count clock tick
// - Compare match raises that register's interrupt
// - Capture edge copies count into register
module timer16_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic timer_input_a,
	input wire logic timer_input_b,
	output logic timer_output_pin,
	output logic match_irq_a,
	output logic match_irq_b
);

	reg_access_if ra ();

	logic [7:0] mode_control_reg;
	logic [7:0] capture_compare_ctrl_reg;
	logic [7:0] output_control_reg;
	logic [7:0] prescaler_mode_reg;
	logic [15:0] count_register;
	logic [15:0] cc_register_a;
	logic [15:0] cc_register_b;
	logic [2:0] div_reg;
	logic out_level_reg;
	logic irq_a_reg;
	logic irq_b_reg;
	logic [7:0] mode_next;
	logic [7:0] outctrl_next;
	logic [15:0] count_next;
	logic [15:0] cc_a_next;
	logic [15:0] cc_b_next;
	logic out_level_next;

	logic valid_a;
	logic reverse_a;
	logic valid_b;

	// Merge written byte lanes into an 8-bit register, honouring reserved bits
	function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] wd,
		input logic be, input logic [7:0] mask);
		return be ? ((old & ~mask) | (wd & mask)) : old;
	endfunction

	// Merge written byte lanes into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	ahb_reg_port u_port (
		.clk(clk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.ra(ra.port)
	);

	timer_input_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pin_a(timer_input_a),
		.pin_b(timer_input_b),
		.edge_sel_a(prescaler_mode_reg[timer16_pkg::PS_ES_A_HI:timer16_pkg::PS_ES_A_LO]),
		.edge_sel_b(prescaler_mode_reg[timer16_pkg::PS_ES_B_HI:timer16_pkg::PS_ES_B_LO]),
		.block_both_a(capture_compare_ctrl_reg[timer16_pkg::CC_A_TRIG]),
		.valid_a(valid_a),
		.reverse_a(reverse_a),
		.valid_b(valid_b)
	);

	// Mode decode straight from the register, so a start takes effect at once
	timer16_pkg::run_mode_t run_mode;
	assign run_mode = timer16_pkg::run_mode_t'(
		mode_control_reg[timer16_pkg::MODE_RUN_HI:timer16_pkg::MODE_RUN_LO]);
	wire running = run_mode != timer16_pkg::RUN_STOP;
	wire inv_sel = mode_control_reg[timer16_pkg::MODE_INV_SEL];
	wire a_capture = capture_compare_ctrl_reg[timer16_pkg::CC_A_MODE];
	wire a_trig_rev = capture_compare_ctrl_reg[timer16_pkg::CC_A_TRIG];
	wire b_capture = capture_compare_ctrl_reg[timer16_pkg::CC_B_MODE];

	// Write strobes per register
	wire wr_lane0 = ra.wr_en && ra.wr_be[0];
	wire wr_mode = wr_lane0 && ra.wr_addr == timer16_pkg::OFF_MODE;
	wire wr_ccctrl = ra.wr_en && ra.wr_addr == timer16_pkg::OFF_CCCTRL;
	wire wr_outctrl = wr_lane0 && ra.wr_addr == timer16_pkg::OFF_OUTCTRL;
	wire wr_prescale = ra.wr_en && ra.wr_addr == timer16_pkg::OFF_PRESCALE;
	wire wr_cc_a = ra.wr_en && ra.wr_addr == timer16_pkg::OFF_CC_A;
	wire wr_cc_b = ra.wr_en && ra.wr_addr == timer16_pkg::OFF_CC_B;

	// Trigger bits act on write and are never stored
	wire oneshot_fire = wr_outctrl && ra.wr_data[timer16_pkg::OC_ONESHOT_TRIG];
	wire level_set = wr_outctrl && !running && ra.wr_data[timer16_pkg::OC_LEVEL_SET];
	wire level_clr = wr_outctrl && !running && ra.wr_data[timer16_pkg::OC_LEVEL_CLR];

	// Count clock: peripheral clock divided by 1, 2, 4 or 8
	logic [2:0] div_mask;
	assign div_mask = 3'(
		(3'h1 << prescaler_mode_reg[timer16_pkg::PS_CLK_HI:timer16_pkg::PS_CLK_LO]) - 3'h1);
	wire tick = running && ((div_reg & div_mask) == div_mask);

	// Compare matches are judged on the value being left at a tick
	wire match_a = running && tick && !a_capture && count_register == cc_register_a;
	wire match_b = running && tick && !b_capture && count_register == cc_register_b;

	// Capture triggers, gated by each register's mode bit; the reverse-A input-B interrupt ignores it
	wire cap_a_b = running && a_capture && !a_trig_rev && valid_b;
	wire cap_a_rev = running && a_capture && a_trig_rev && reverse_a;
	wire ext_irq_a = running && a_trig_rev && valid_b;
	wire cap_b = running && b_capture && valid_a;

	// Clear-and-start sources
	wire clr_edge = run_mode == timer16_pkg::RUN_CLR_EDGE && valid_a;
	wire clr_match = run_mode == timer16_pkg::RUN_CLR_MATCH && match_a;
	wire clr_start = running && (clr_edge || oneshot_fire);
	// Only a true FFFF wrap flags overflow; a match clear is not an overflow
	wire overflow = tick && count_register == timer16_pkg::COUNT_MAX;
	wire wrap = overflow || clr_match;

	// Counter next value; stop clears it, clear events beat a tick
	always_comb begin
		count_next = count_register;
		if (!running) begin
			count_next = timer16_pkg::RST_WORD;
		end else if (clr_start) begin
			count_next = timer16_pkg::RST_WORD;
		end else if (wrap) begin
			count_next = timer16_pkg::RST_WORD;
		end else if (tick) begin
			count_next = 16'(count_register + timer16_pkg::COUNT_ONE);
		end
	end

	// Mode register; an overflow wins over a same-cycle clear by software
	always_comb begin
		mode_next = merge8(mode_control_reg, ra.wr_data[7:0], wr_mode,
			timer16_pkg::MASK_MODE);
		if (running && overflow) begin
			mode_next[timer16_pkg::MODE_OVF] = 1'b1;
		end
		if (!running) begin
			mode_next[timer16_pkg::MODE_OVF] = 1'b0;
		end
	end

	// Output control: while running only the B-invert bit may change
	always_comb begin
		outctrl_next = merge8(output_control_reg, ra.wr_data[7:0], wr_outctrl,
			running ? timer16_pkg::MASK_OUTCTRL_RUN : timer16_pkg::MASK_OUTCTRL);
	end

	// Capture registers: a capture wins over a software write
	always_comb begin
		cc_a_next = wr_cc_a ? merge16(cc_register_a, ra.wr_data, ra.wr_be) : cc_register_a;
		if (cap_a_b || cap_a_rev) begin
			cc_a_next = count_register;
		end
		cc_b_next = wr_cc_b ? merge16(cc_register_b, ra.wr_data, ra.wr_be) : cc_register_b;
		if (cap_b) begin
			cc_b_next = count_register;
		end
	end

	// Output level: disabled output sits low, level triggers, then toggles
	wire toggle = (match_a && output_control_reg[timer16_pkg::OC_A_INV_EN])
		|| (match_b && output_control_reg[timer16_pkg::OC_B_INV_EN])
		|| (running && inv_sel && valid_a);
	always_comb begin
		out_level_next = out_level_reg;
		if (!output_control_reg[timer16_pkg::OC_OUT_EN]) begin
			out_level_next = 1'b0;
		end else if (level_set) begin
			out_level_next = 1'b1;
		end else if (level_clr) begin
			out_level_next = 1'b0;
		end else if (toggle) begin
			out_level_next = !out_level_reg;
		end
	end

	// Control registers
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_control_reg <= timer16_pkg::RST_BYTE;
			capture_compare_ctrl_reg <= timer16_pkg::RST_BYTE;
			output_control_reg <= timer16_pkg::RST_BYTE;
			prescaler_mode_reg <= timer16_pkg::RST_BYTE;
		end else begin
			mode_control_reg <= mode_next;
			capture_compare_ctrl_reg <= merge8(capture_compare_ctrl_reg, ra.wr_data[7:0],
				wr_ccctrl && ra.wr_be[0], timer16_pkg::MASK_CCCTRL);
			output_control_reg <= outctrl_next;
			prescaler_mode_reg <= merge8(prescaler_mode_reg, ra.wr_data[7:0],
				wr_prescale && ra.wr_be[0], timer16_pkg::MASK_PRESCALE);
		end
	end

	// Counting state, capture values and outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			count_register <= timer16_pkg::RST_WORD;
			cc_register_a <= timer16_pkg::RST_WORD;
			cc_register_b <= timer16_pkg::RST_WORD;
			div_reg <= 3'h0;
			out_level_reg <= 1'b0;
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
		end else begin
			count_register <= count_next;
			cc_register_a <= cc_a_next;
			cc_register_b <= cc_b_next;
			div_reg <= (running && !clr_start) ? 3'(div_reg + 3'h1) : 3'h0;
			out_level_reg <= out_level_next;
			// Reverse-phase captures raise no interrupt
			irq_a_reg <= match_a || cap_a_b || ext_irq_a;
			irq_b_reg <= match_b || cap_b;
		end
	end

	assign timer_output_pin = out_level_reg;
	assign match_irq_a = irq_a_reg;
	assign match_irq_b = irq_b_reg;

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		case (ra.rd_addr)
			timer16_pkg::OFF_MODE: ra.rd_data = {24'h000000, mode_control_reg};
			timer16_pkg::OFF_CCCTRL: ra.rd_data = {24'h000000, capture_compare_ctrl_reg};
			timer16_pkg::OFF_OUTCTRL: ra.rd_data = {24'h000000, output_control_reg};
			timer16_pkg::OFF_PRESCALE: ra.rd_data = {24'h000000, prescaler_mode_reg};
			timer16_pkg::OFF_COUNT: ra.rd_data = {16'h0000, count_register};
			timer16_pkg::OFF_CC_A: ra.rd_data = {16'h0000, cc_register_a};
			timer16_pkg::OFF_CC_B: ra.rd_data = {16'h0000, cc_register_b};
			default: ra.rd_data = 32'h00000000;
		endcase
	end

endmodule

// file: core/timer16_pkg.sv
// Constants, field positions and types shared by the timer channel files
package timer16_pkg;

	// Register byte offsets on the bus
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_CCCTRL = 8'h04;
	localparam logic [7:0] OFF_OUTCTRL = 8'h08;
	localparam logic [7:0] OFF_PRESCALE = 8'h0C;
	localparam logic [7:0] OFF_COUNT = 8'h10;
	localparam logic [7:0] OFF_CC_A = 8'h14;
	localparam logic [7:0] OFF_CC_B = 8'h18;

	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// Writable bits of each 8-bit register; other positions are reserved
	localparam logic [7:0] MASK_MODE = 8'h0F;
	localparam logic [7:0] MASK_CCCTRL = 8'h07;
	localparam logic [7:0] MASK_OUTCTRL = 8'h33;
	localparam logic [7:0] MASK_PRESCALE = 8'hF3;
	// Bits of the output control register writable while running
	localparam logic [7:0] MASK_OUTCTRL_RUN = 8'h10;

	// Mode control register fields
	localparam int MODE_RUN_HI = 3;
	localparam int MODE_RUN_LO = 2;
	localparam int MODE_INV_SEL = 1;
	localparam int MODE_OVF = 0;

	// Capture/compare control fields
	localparam int CC_B_MODE = 2;
	localparam int CC_A_TRIG = 1;
	localparam int CC_A_MODE = 0;

	// Output control fields
	localparam int OC_ONESHOT_TRIG = 6;
	localparam int OC_ONESHOT_EN = 5;
	localparam int OC_B_INV_EN = 4;
	localparam int OC_LEVEL_SET = 3;
	localparam int OC_LEVEL_CLR = 2;
	localparam int OC_A_INV_EN = 1;
	localparam int OC_OUT_EN = 0;

	// Prescaler mode fields
	localparam int PS_ES_B_HI = 7;
	localparam int PS_ES_B_LO = 6;
	localparam int PS_ES_A_HI = 5;
	localparam int PS_ES_A_LO = 4;
	localparam int PS_CLK_HI = 1;
	localparam int PS_CLK_LO = 0;

	// Edge select codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Count value limits
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	// Operating mode, in the order of the two-bit run field
	typedef enum logic [1:0] {
		RUN_STOP,
		RUN_FREE,
		RUN_CLR_EDGE,
		RUN_CLR_MATCH
	} run_mode_t;

endpackage

// file: core/timer_input_sync.sv
// Two-stage synchronisers and valid-edge detection for both timer inputs
`timescale 1ns/100ps
module timer_input_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pin_a,
	input wire logic pin_b,
	input wire logic [1:0] edge_sel_a,
	input wire logic [1:0] edge_sel_b,
	input wire logic block_both_a,
	output logic valid_a,
	output logic reverse_a,
	output logic valid_b
);

	logic [2:0] sync_a_reg;
	logic [2:0] sync_b_reg;

	// Edge match for a select code; code 10 selects nothing
	function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
		input logic fall);
		logic h;
		h = 1'b0;
		case (sel)
			timer16_pkg::EDGE_FALL: h = fall;
			timer16_pkg::EDGE_RISE: h = rise;
			timer16_pkg::EDGE_BOTH: h = rise || fall;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// Stage 0 feeds only stage 1; edges are read from stages 1 and 2
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_a_reg <= 3'h0;
			sync_b_reg <= 3'h0;
		end else begin
			sync_a_reg <= {sync_a_reg[1:0], pin_a};
			sync_b_reg <= {sync_b_reg[1:0], pin_b};
		end
	end

	wire rise_a = sync_a_reg[1] && !sync_a_reg[2];
	wire fall_a = !sync_a_reg[1] && sync_a_reg[2];
	wire rise_b = sync_b_reg[1] && !sync_b_reg[2];
	wire fall_b = !sync_b_reg[1] && sync_b_reg[2];
	// Both-edge selection has no opposite phase, so with block_both_a set it kills input A
	wire a_dead = block_both_a && edge_sel_a == timer16_pkg::EDGE_BOTH;

	assign valid_a = !a_dead && edge_hit(edge_sel_a, rise_a, fall_a);
	assign reverse_a = !a_dead && edge_hit(edge_sel_a, fall_a, rise_a);
	assign valid_b = edge_hit(edge_sel_b, rise_b, fall_b);

endmodule

// file: testbench/timer16_channel_properties.sv
// Bus timing and event output properties of the timer channel
`timescale 1ns/100ps
module timer16_channel_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic timer_input_a,
	input wire logic timer_input_b,
	input wire logic timer_output_pin,
	input wire logic match_irq_a,
	input wire logic match_irq_b
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Accepted transfers, split by direction
	wire logic rd_req = hsel && hready && htrans[1] && !hwrite;
	wire logic wr_req = hsel && hready && htrans[1] && hwrite;

	property p_reset_quiet;
		$past(rst) |-> hreadyout && !timer_output_pin && !match_irq_a && !match_irq_b
			&& hrdata == 32'h0;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");

	property p_read_wait;
		rd_req |=> !hreadyout ##1 hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read did not take one wait state");

	property p_write_fast;
		wr_req |=> hreadyout;
	endproperty
	a_write_fast: assert property (p_write_fast) else $error("write stalled the bus");

	// A stall longer than one cycle would hang a zero-wait master
	property p_one_wait;
		!hreadyout |=> hreadyout;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("hreadyout low two cycles");

	property p_rdata_hold;
		hreadyout && $past(hreadyout) |-> $stable(hrdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata changed without a read");

	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not OKAY");

	property p_irq_a_pulse;
		match_irq_a |=> !match_irq_a;
	endproperty
	a_irq_a_pulse: assert property (p_irq_a_pulse) else $error("irq a longer than one cycle");

	property p_irq_b_pulse;
		match_irq_b |=> !match_irq_b;
	endproperty
	a_irq_b_pulse: assert property (p_irq_b_pulse) else $error("irq b longer than one cycle");
endmodule

bind timer16_channel timer16_channel_properties timer16_channel_properties_i (.clk(clk),
	.rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.timer_input_a(timer_input_a), .timer_input_b(timer_input_b),
	.timer_output_pin(timer_output_pin), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));

// file: testbench/timer16_channel_tb_top.sv
// Self-checking bench for the timer channel
`timescale 1ns/100ps
module timer16_channel_tb_top;
	localparam logic [7:0] MD = timer16_pkg::OFF_MODE;
	localparam logic [7:0] CC = timer16_pkg::OFF_CCCTRL;
	localparam logic [7:0] OC = timer16_pkg::OFF_OUTCTRL;
	localparam logic [7:0] PS = timer16_pkg::OFF_PRESCALE;
	localparam logic [7:0] CNT = timer16_pkg::OFF_COUNT;
	localparam logic [7:0] CA = timer16_pkg::OFF_CC_A;
	localparam logic [7:0] CB = timer16_pkg::OFF_CC_B;
	logic clk;
	logic rst;
	logic hsel;
	logic hwrite;
	logic fire_a;
	logic fire_b;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout;
	logic hresp;
	logic pin_a;
	logic pin_b;
	logic tout;
	logic irq_a;
	logic irq_b;
	logic p;
	logic seen;
	logic [15:0] n;
	logic [15:0] c1;
	logic [15:0] v;
	int mismatches;
	int check_count;
	int k;

	timer16_channel timer16_channel_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .timer_input_a(pin_a),
		.timer_input_b(pin_b), .timer_output_pin(tout), .match_irq_a(irq_a), .match_irq_b(irq_b));
	timer_pins_model timer_pins_model_i (.clk(clk), .rst(rst), .fire_a(fire_a),
		.fire_b(fire_b), .pin_a(pin_a), .pin_b(pin_b));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		check_val({31'h0, got}, {31'h0, exp});
	endtask

	// One single transfer; both phases held until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= sz;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, 3'h2, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 3'h2, 32'h0);
		check_val(rd, exp);
	endtask

	task automatic pulse(input logic b);
		if (b)
			fire_b <= 1'b1;
		else
			fire_a <= 1'b1;
		@(posedge clk);
		fire_a <= 1'b0;
		fire_b <= 1'b0;
	endtask

	// Bounded wait for one interrupt pulse, back on the rising edge after
	task automatic wait_irq(input logic b);
		seen = 1'b0;
		for (k = 0; k < 40 && !seen; k++) begin
			@(negedge clk);
			seen = b ? (irq_b === 1'b1) : (irq_a === 1'b1);
		end
		@(posedge clk);
	endtask

	// Run one toggle trial: pin must flip only when an A edge is meant to act
	task automatic toggle_trial(input logic [7:0] mode, input logic flips);
		wr(MD, 32'h0);
		wr(MD, {24'h0, mode});
		repeat (2) @(posedge clk);
		p = tout;
		pulse(1'b0);
		repeat (10) @(posedge clk);
		check_bit(tout, flips ? ~p : p);
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog sized above the long overflow wait
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		conclude();
	end

	initial begin
		{rst, hsel, hwrite, fire_a, fire_b} = 5'h10;
		{haddr, hwdata, htrans, hsize} = '0;
		mismatches = 0;
		check_count = 0;
		void'($urandom(32'h355E));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		// Reset values of every register, then an unmapped offset
		for (int i = 0; i < 7; i++) rdchk(8'(4 * i), 32'h0);
		rdchk(8'h1C, 32'h0);
		v = 16'($urandom);
		wr(CC, {24'h0, v[7:0]});
		rdchk(CC, {24'h0, v[7:0] & timer16_pkg::MASK_CCCTRL});
		wr(CC, 32'h0);
		bus(1'b1, MD, 3'h0, 32'h2);
		rdchk(MD, 32'h2);
		wr(MD, 32'h0);
		// Free run: compare A fires n+1 cycles after start
		n = 16'(2 + $urandom % 39);
		wr(CA, {16'h0, n});
		wr(MD, 32'h4);
		k = 0;
		@(negedge clk);
		while (irq_a !== 1'b1 && k < 100) begin
			k++;
			@(negedge clk);
		end
		@(posedge clk);
		check_val(32'(k), 32'(n) + 32'h1);
		// Hardware wrap, then software clear, set and stop
		repeat (65540) @(posedge clk);
		rdchk(MD, 32'h5);
		wr(MD, 32'h4);
		rdchk(MD, 32'h4);
		wr(MD, 32'h5);
		rdchk(MD, 32'h5);
		wr(MD, 32'h0);
		rdchk(MD, 32'h0);
		rdchk(CNT, 32'h0);
		// Clear on compare A keeps the count at or below n
		wr(MD, 32'hC);
		// Long enough that an uncleared count would pass n
		repeat (100) @(posedge clk);
		repeat (3) begin
			bus(1'b0, CNT, 3'h2, 32'h0);
			check_bit(rd[15:0] <= n, 1'b1);
		end
		rdchk(MD, 32'hC);
		// Clear on input A rising edge
		wr(MD, 32'h0);
		wr(PS, 32'h10);
		wr(MD, 32'h8);
		repeat (60) @(posedge clk);
		pulse(1'b0);
		repeat (8) @(posedge clk);
		bus(1'b0, CNT, 3'h2, 32'h0);
		check_bit(rd[15:0] < 16'h14, 1'b1);
		// Output toggling by input A edges
		wr(MD, 32'h0);
		wr(CA, 32'hFFFF);
		wr(CB, 32'hFFFF);
		wr(OC, 32'h3);
		toggle_trial(8'h6, 1'b1);
		wr(OC, 32'h10);
		rdchk(OC, 32'h13);
		toggle_trial(8'h4, 1'b0);
		wr(MD, 32'h0);
		wr(CC, 32'h2);
		wr(PS, 32'h30);
		toggle_trial(8'h6, 1'b0);
		// Capture into A on an input B edge
		wr(MD, 32'h0);
		wr(CC, 32'h1);
		wr(PS, 32'h40);
		wr(MD, 32'h4);
		bus(1'b0, CNT, 3'h2, 32'h0);
		c1 = rd[15:0];
		pulse(1'b1);
		wait_irq(1'b0);
		check_bit(seen, 1'b1);
		bus(1'b0, CA, 3'h2, 32'h0);
		v = rd[15:0];
		bus(1'b0, CNT, 3'h2, 32'h0);
		check_bit(v > c1 && v < rd[15:0], 1'b1);
		// Reverse-A trigger: input B only raises the interrupt
		wr(MD, 32'h0);
		wr(CC, 32'h3);
		wr(MD, 32'h4);
		repeat (20) @(posedge clk);
		pulse(1'b1);
		wait_irq(1'b0);
		check_bit(seen, 1'b1);
		rdchk(CA, {16'h0, v});
		// Compare on register B
		wr(MD, 32'h0);
		wr(CC, 32'h0);
		wr(CB, 32'h5);
		wr(MD, 32'h4);
		wait_irq(1'b1);
		check_bit(seen, 1'b1);
		wr(MD, 32'h0);
		// Count clock at one eighth: about ten ticks in eighty cycles
		wr(PS, 32'h43);
		wr(MD, 32'h4);
		repeat (80) @(posedge clk);
		bus(1'b0, CNT, 3'h2, 32'h0);
		check_bit(rd[15:0] > 16'h8 && rd[15:0] < 16'hC, 1'b1);
		wr(MD, 32'h0);
		conclude();
	end
endmodule

// file: testbench/timer_pins_model.sv
// Model of the external trigger sources on both timer input pins
`timescale 1ns/100ps
module timer_pins_model #(
	parameter int PULSE_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fire_a,
	input wire logic fire_b,
	output logic pin_a,
	output logic pin_b
);
	int cnt_a;
	int cnt_b;

	// Pulses outlast the two-stage input synchroniser by two cycles so captures are not missed
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_a <= 0;
			cnt_b <= 0;
		end else begin
			cnt_a <= fire_a ? PULSE_CYCLES : (cnt_a > 0 ? cnt_a - 1 : 0);
			cnt_b <= fire_b ? PULSE_CYCLES : (cnt_b > 0 ? cnt_b - 1 : 0);
		end
	end

	// Pins idle low between pulses
	assign pin_a = cnt_a > 0;
	assign pin_b = cnt_b > 0;
endmodule
